// ---- design/ccfg_defines.vh ----
/*
  Constants of the converter configuration register block: byte
  addresses, field positions, reset values and counter limits.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CCFG_DEFINES_VH
`define CCFG_DEFINES_VH

// Byte addresses of the instruction address field
`define CCFG_ADDR_DOR2      4'h0
`define CCFG_ADDR_DOR1      4'h1
`define CCFG_ADDR_DOR0      4'h2
`define CCFG_ADDR_CFG3      4'h4
`define CCFG_ADDR_CFG2      4'h5
`define CCFG_ADDR_CFG1      4'h6
`define CCFG_ADDR_CFG0      4'h7

// Configuration register reset value and fields
`define CCFG_CFG_RESET      32'h40000017
`define CCFG_BIAS_BIT       31
`define CCFG_INTERNAL_REF_ENABLE_BIT       30
`define CCFG_FMT_BIT        29
`define CCFG_UNI_BIT        28
`define CCFG_BYTE_BIT       27
`define CCFG_BITO_BIT       26
`define CCFG_LINE_BIT       25
`define CCFG_RSYNC_BIT      24
`define CCFG_MODE_HI        23
`define CCFG_MODE_LO        21
`define CCFG_GAIN_HI        20
`define CCFG_GAIN_LO        18
`define CCFG_CHAN_HI        17
`define CCFG_CHAN_LO        16
`define CCFG_SPEED_HI       15
`define CCFG_SPEED_LO       13
`define CCFG_DEC_HI         12
`define CCFG_DEC_LO         0

// Instruction byte fields
`define CCFG_INS_RW_BIT     7
`define CCFG_INS_NB_HI      6
`define CCFG_INS_NB_LO      5
`define CCFG_INS_AD_HI      3
`define CCFG_INS_AD_LO      0

// Ready indications carrying stale data after a channel change, last bit of a byte, result reset value
`define CCFG_INVALID_COUNT  2'h3
`define CCFG_LAST_BIT       3'h7
`define CCFG_DOR_RESET      24'h000000

`endif

// ---- design/ccfg_sync.v ----
/*
  Input synchroniser: three stages plus an output flip-flop per bit; the output takes a
  new value only once the second and third stages agree.
  Assumes inputs asynchronous to clk and a synchronous reset.
*/
`timescale 1ns/1ns
module ccfg_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,      // System clock
  input  wire             sys_rst,  // Synchronous reset, active high
  input  wire [WIDTH-1:0] async_in, // Raw inputs
  output wire [WIDTH-1:0] sync_out  // Filtered synchronous inputs
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] out_reg;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clk)
      begin
        if (sys_rst)
          out_reg[i] <= RESET_VAL[i];
        else if (s2_reg[i] == s3_reg[i])
          out_reg[i] <= s3_reg[i];
      end
    end
  endgenerate

  assign sync_out = out_reg;

endmodule

// ---- design/ccfg_top.v ----
/*
  Converter configuration register with its serial port: an
  instruction byte, then one to four data bytes read or written.
  Assumes a host clocking the serial clock slowly against clk, a
  chip select framing each transfer, and conversion results arriving
  as one-cycle strobes from the modulator logic.
*/
`timescale 1ns/1ns
`include "ccfg_defines.vh"
module ccfg_top (
  input  wire        clk,                 // System clock, 20 MHz
  input  wire        sys_rst,             // Synchronous reset, active high
  input  wire        serial_clk,          // Serial clock from host
  input  wire        select_n,            // Transfer frame, active low
  input  wire        sdio_in,             // Data pin, input side
  output wire        sdio_out,            // Data pin, output side
  output wire        sdio_oe,             // Data pin output enable
  output wire        dedicated_serial_out, // Dedicated output pin data
  output wire        dedicated_serial_oe, // Dedicated output pin enable
  input  wire        result_ready_n,      // Ready pin level, low when ready
  input  wire        conv_strobe,         // New raw result, one-cycle pulse
  input  wire [23:0] conv_data,           // Raw two's complement result
  output wire        bias_enable,         // Bias generator on
  output wire        internal_ref_enable, // Reference output driven
  output wire        result_format_select, // Offset binary when high
  output wire        unipolar_enable,     // Negative results clamped
  output wire        byte_sequence_select, // Reads descend when high
  output wire        bit_sequence_select, // Reads LSB first when high
  output wire        output_line_select,  // Read data on dedicated pin
  output wire        modulator_resync,    // Count reset, one-cycle pulse
  output wire [2:0]  operating_mode_field, // Operating mode
  output wire [2:0]  gain_field,          // Gain code
  output wire [1:0]  input_channel_field, // Input channel
  output wire [2:0]  modulator_speed_field, // Modulator speed code
  output wire [12:0] decimation_field,    // Decimation ratio
  output wire [23:0] result_out,          // Output register contents
  output wire        result_valid         // Output data trustworthy
);

  localparam [1:0] ST_INSTR = 2'b01;
  localparam [1:0] ST_DATA  = 2'b10;

  wire [3:0] sync_q;
  wire       sclk_s;
  wire       sel_n_s;
  wire       din_s;
  wire       rdy_n_s;

  reg        sclk_d_reg;
  reg        rdy_d_reg;
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [2:0]  bit_cnt_reg;
  reg        byte_done_reg;
  reg [1:0]  bytes_left_reg;
  reg [3:0]  addr_reg;
  reg        read_reg;
  reg [7:0]  rx_reg;
  reg [7:0]  tx_reg;
  reg [31:0] cfg_reg;
  reg [23:0] dor_reg;
  reg        resync_reg;
  reg [1:0]  invalid_cnt_reg;
  reg        stale_reg;

  wire       active;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       rdy_fall;
  wire [3:0] ins_addr;
  wire [3:0] next_addr;
  wire [7:0] fetch_byte;
  wire [23:0] clamped;
  wire       chan_write;

  ccfg_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'hB)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({select_n, serial_clk, sdio_in, result_ready_n}),
    .sync_out (sync_q)
  );

  assign sel_n_s = sync_q[3];
  assign sclk_s  = sync_q[2];
  assign din_s   = sync_q[1];
  assign rdy_n_s = sync_q[0];

  assign active    = ~sel_n_s;
  assign sclk_rise = active & sclk_s & ~sclk_d_reg;
  assign sclk_fall = active & ~sclk_s & sclk_d_reg;
  assign rdy_fall  = ~rdy_n_s & rdy_d_reg;

  assign ins_addr = rx_reg[`CCFG_INS_AD_HI:`CCFG_INS_AD_LO];

  // Reads may descend; writes always ascend
  assign next_addr = (read_reg & cfg_reg[`CCFG_BYTE_BIT]) ?
                     addr_reg - 4'h1 : addr_reg + 4'h1;

  // Byte presented for a read at a given address
  function [7:0] read_byte;
    input [3:0]  a;
    input [31:0] cfg;
    input [23:0] dor;
    input        rdy_n;
    begin
      case (a)
        `CCFG_ADDR_DOR2: read_byte = dor[23:16];
        `CCFG_ADDR_DOR1: read_byte = dor[15:8];
        `CCFG_ADDR_DOR0: read_byte = dor[7:0];
        `CCFG_ADDR_CFG3: read_byte = {cfg[31:25], rdy_n};
        `CCFG_ADDR_CFG2: read_byte = cfg[23:16];
        `CCFG_ADDR_CFG1: read_byte = cfg[15:8];
        `CCFG_ADDR_CFG0: read_byte = cfg[7:0];
        default:         read_byte = 8'h00;
      endcase
    end
  endfunction

  // Within-byte bit order for reads
  function [7:0] order_bits;
    input [7:0] b;
    input       lsb_first;
    integer k;
    begin
      order_bits = b;
      if (lsb_first)
        for (k = 0; k < 8; k = k + 1)
          order_bits[k] = b[7-k];
    end
  endfunction

  assign fetch_byte = order_bits(
    read_byte((state_reg == ST_INSTR) ? ins_addr : next_addr,
              cfg_reg, dor_reg, rdy_n_s),
    cfg_reg[`CCFG_BITO_BIT]);

  // Clamp first, then set the format of the stored result only
  assign clamped = (cfg_reg[`CCFG_UNI_BIT] & conv_data[23]) ?
                   24'h000000 : conv_data;

  // Committed write of the second byte that picks another channel
  assign chan_write = sclk_fall & byte_done_reg & (state_reg == ST_DATA) & ~read_reg &
                      (addr_reg == `CCFG_ADDR_CFG2) &
                      (rx_reg[1:0] != cfg_reg[`CCFG_CHAN_HI:`CCFG_CHAN_LO]);

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclk_d_reg <= 1'b0;
      rdy_d_reg  <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      rdy_d_reg  <= rdy_n_s;
    end
  end

  // Transfer sequencing
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_INSTR:
        if (sclk_fall & byte_done_reg)
          state_next = ST_DATA;
      ST_DATA:
        if (sclk_fall & byte_done_reg & (bytes_left_reg == 2'h0))
          state_next = ST_INSTR;
      default:
        state_next = ST_INSTR;
    endcase
    if (!active)
      state_next = ST_INSTR;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
      state_reg <= ST_INSTR;
    else
      state_reg <= state_next;
  end

  // Bit capture on rising serial clock
  always @(posedge clk)
  begin
    if (sys_rst | ~active)
    begin
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
      rx_reg        <= 8'h00;
    end
    else if (sclk_rise)
    begin
      rx_reg        <= {rx_reg[6:0], din_s};
      bit_cnt_reg   <= bit_cnt_reg + 3'h1;
      byte_done_reg <= (bit_cnt_reg == `CCFG_LAST_BIT);
    end
    else if (sclk_fall & byte_done_reg)
      byte_done_reg <= 1'b0;
  end

  // Instruction decode, address stepping and read shifting
  always @(posedge clk)
  begin
    if (sys_rst | ~active)
    begin
      bytes_left_reg <= 2'h0;
      addr_reg       <= 4'h0;
      read_reg       <= 1'b0;
      tx_reg         <= 8'h00;
    end
    else if (sclk_fall)
    begin
      if (byte_done_reg)
      begin
        if (state_reg == ST_INSTR)
        begin
          read_reg       <= rx_reg[`CCFG_INS_RW_BIT];
          bytes_left_reg <= rx_reg[`CCFG_INS_NB_HI:`CCFG_INS_NB_LO];
          addr_reg       <= ins_addr;
          tx_reg         <= fetch_byte;
        end
        else if (bytes_left_reg != 2'h0)
        begin
          bytes_left_reg <= bytes_left_reg - 2'h1;
          addr_reg       <= next_addr;
          tx_reg         <= fetch_byte;
        end
      end
      else
        tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // Configuration writes commit at the falling edge of each last bit
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_reg    <= `CCFG_CFG_RESET;
      resync_reg <= 1'b0;
    end
    else
    begin
      resync_reg <= 1'b0;
      if (sclk_fall & byte_done_reg & (state_reg == ST_DATA) & ~read_reg)
      begin
        case (addr_reg)
          `CCFG_ADDR_CFG3:
          begin
            cfg_reg[31:25] <= rx_reg[7:1];
            resync_reg     <= rx_reg[0];
          end
          `CCFG_ADDR_CFG2: cfg_reg[23:16] <= rx_reg;
          `CCFG_ADDR_CFG1: cfg_reg[15:8]  <= rx_reg;
          `CCFG_ADDR_CFG0: cfg_reg[7:0]   <= rx_reg;
          default:         cfg_reg        <= cfg_reg;
        endcase
      end
    end
  end

  // Output register: clamp and format affect only this copy
  always @(posedge clk)
  begin
    if (sys_rst)
      dor_reg <= `CCFG_DOR_RESET;
    else if (conv_strobe)
      dor_reg <= {clamped[23] ^ cfg_reg[`CCFG_FMT_BIT], clamped[22:0]};
  end

  // Stale results after a channel change
  always @(posedge clk)
  begin
    if (sys_rst)
      invalid_cnt_reg <= 2'h0;
    else if (chan_write)
      invalid_cnt_reg <= `CCFG_INVALID_COUNT;
    else if (rdy_fall & (invalid_cnt_reg != 2'h0))
      invalid_cnt_reg <= invalid_cnt_reg - 2'h1;
  end

  // Stale until the ready fall after the last stale one
  // A new channel write in the same cycle as a fall wins
  always @(posedge clk)
  begin
    if (sys_rst)
      stale_reg <= 1'b0;
    else if (chan_write)
      stale_reg <= 1'b1;
    else if (rdy_fall & (invalid_cnt_reg == 2'h0))
      stale_reg <= 1'b0;
  end

  // Pin drive during the data phase of a read
  assign sdio_out             = tx_reg[7];
  assign sdio_oe              = active & (state_reg == ST_DATA) & read_reg &
                                ~cfg_reg[`CCFG_LINE_BIT];
  assign dedicated_serial_out = tx_reg[7];
  assign dedicated_serial_oe  = active & (state_reg == ST_DATA) & read_reg &
                                cfg_reg[`CCFG_LINE_BIT];

  assign bias_enable           = cfg_reg[`CCFG_BIAS_BIT];
  assign internal_ref_enable   = cfg_reg[`CCFG_INTERNAL_REF_ENABLE_BIT];
  assign result_format_select  = cfg_reg[`CCFG_FMT_BIT];
  assign unipolar_enable       = cfg_reg[`CCFG_UNI_BIT];
  assign byte_sequence_select  = cfg_reg[`CCFG_BYTE_BIT];
  assign bit_sequence_select   = cfg_reg[`CCFG_BITO_BIT];
  assign output_line_select    = cfg_reg[`CCFG_LINE_BIT];
  assign modulator_resync      = resync_reg;
  assign operating_mode_field  = cfg_reg[`CCFG_MODE_HI:`CCFG_MODE_LO];
  assign gain_field            = cfg_reg[`CCFG_GAIN_HI:`CCFG_GAIN_LO];
  assign input_channel_field   = cfg_reg[`CCFG_CHAN_HI:`CCFG_CHAN_LO];
  assign modulator_speed_field = cfg_reg[`CCFG_SPEED_HI:`CCFG_SPEED_LO];
  assign decimation_field      = cfg_reg[`CCFG_DEC_HI:`CCFG_DEC_LO];
  assign result_out            = dor_reg;
  assign result_valid          = ~stale_reg;

endmodule

// ---- tb/ccfg_top_sva.sv ----
/* Checker for the configuration register block: pin drive, result path and update timing.
   Assumes binding onto ccfg_top and one clock domain. */
`timescale 1ns/1ns
module ccfg_top_sva (
  input wire        clk,                   // System clock
  input wire        sys_rst,               // Synchronous reset
  input wire        select_n,              // Transfer frame
  input wire        sdio_oe,               // Data pin enable
  input wire        dedicated_serial_oe,   // Dedicated pin enable
  input wire        output_line_select,    // Read line choice
  input wire        modulator_resync,      // Count reset pulse
  input wire        bias_enable,           // Bias generator on
  input wire [2:0]  operating_mode_field,  // Mode
  input wire [2:0]  gain_field,            // Gain
  input wire [2:0]  modulator_speed_field, // Speed
  input wire [12:0] decimation_field,      // Decimation
  input wire [1:0]  input_channel_field,   // Channel
  input wire        result_valid,          // Output data trustworthy
  input wire        conv_strobe,           // New raw result
  input wire [23:0] conv_data,             // Raw result
  input wire        result_format_select,  // Offset binary
  input wire        unipolar_enable,       // Clamp negatives
  input wire [23:0] result_out             // Output register
);
  reg [23:0] cd_q;
  reg        fmt_q;
  always @(posedge clk)
  begin
    cd_q  <= conv_data;
    fmt_q <= result_format_select;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pins_exclusive: assert property (!(sdio_oe && dedicated_serial_oe))
    else $error("both data pins driven");
  a_ded_off_line0: assert property (!output_line_select |-> !dedicated_serial_oe)
    else $error("dedicated pin driven with line select 0");
  a_sdio_off_line1: assert property (output_line_select |-> !sdio_oe)
    else $error("data pin driven with line select 1");
  a_drive_in_frame: assert property ($rose(sdio_oe || dedicated_serial_oe) |-> !select_n)
    else $error("pin driven outside a frame");
  a_release_idle: assert property (select_n [*8] |-> !sdio_oe && !dedicated_serial_oe)
    else $error("pin still driven after frame end");
  a_resync_single: assert property (modulator_resync |=> !modulator_resync)
    else $error("resync pulse longer than one cycle");
  a_cfg_in_frame: assert property ($changed({bias_enable, operating_mode_field, gain_field,
    modulator_speed_field, decimation_field}) |-> !$past(select_n, 2))
    else $error("configuration changed outside a write");
  a_chan_invalid: assert property ($changed(input_channel_field) |-> ##[0:1] !result_valid)
    else $error("result valid kept after channel change");
  a_format_msb: assert property (conv_strobe && !unipolar_enable
    |=> result_out == {cd_q[23] ^ fmt_q, cd_q[22:0]})
    else $error("stored result format wrong");
  a_clamp_neg: assert property (conv_strobe && unipolar_enable && conv_data[23]
    |=> result_out == {fmt_q, 23'h000000})
    else $error("negative result not clamped");
endmodule
bind ccfg_top ccfg_top_sva u_ccfg_top_sva (.clk(clk), .sys_rst(sys_rst), .select_n(select_n),
  .sdio_oe(sdio_oe), .dedicated_serial_oe(dedicated_serial_oe),
  .output_line_select(output_line_select), .modulator_resync(modulator_resync),
  .bias_enable(bias_enable), .operating_mode_field(operating_mode_field),
  .gain_field(gain_field), .modulator_speed_field(modulator_speed_field),
  .decimation_field(decimation_field), .input_channel_field(input_channel_field),
  .result_valid(result_valid), .conv_strobe(conv_strobe), .conv_data(conv_data),
  .result_format_select(result_format_select), .unipolar_enable(unipolar_enable),
  .result_out(result_out));

// ---- tb/ccfg_host.sv ----
/* Host controller model: frames, serial clock of 400 ns, read byte capture.
   Assumes clk at 20 MHz. */
`timescale 1ns/1ns
module ccfg_host (
  input  wire       clk,        // System clock
  output reg        serial_clk, // Serial clock, idle low
  output reg        select_n,   // Frame, active low
  output wire       sdio_in,    // Resolved data pin
  input  wire       sdio_out,   // Device data bit
  input  wire       sdio_oe,    // Device drives data pin
  input  wire       ded_out,    // Dedicated pin bit
  input  wire       ded_oe,     // Dedicated pin enable
  output reg        rx_done,    // Read byte complete
  output reg  [7:0] rx_byte     // Read byte
);
  reg host_bit;
  assign sdio_in = sdio_oe ? sdio_out : host_bit;
  initial
  begin
    serial_clk = 1'b0;
    select_n   = 1'b1;
    host_bit   = 1'b1;
    rx_done    = 1'b0;
    rx_byte    = 8'h00;
  end
  task byte_io(input [7:0] tx, input rd);
    integer i;
    reg [7:0] v;
    begin
      v = 8'h00;
      for (i = 7; i >= 0; i = i - 1)
      begin
        // Released pin toggles so stale levels never match
        host_bit <= rd ? ~host_bit : tx[i];
        repeat (4) @(posedge clk);
        serial_clk <= 1'b1;
        repeat (4) @(posedge clk);
        // A released dedicated pin reads inverted so it never matches
        v = {v[6:0], sdio_oe ? sdio_in : (ded_oe ? ded_out : ~ded_out)};
        serial_clk <= 1'b0;
      end
      rx_byte <= v;
      rx_done <= rd;
      @(posedge clk);
      rx_done <= 1'b0;
    end
  endtask
  task xfer(input [7:0] ins, input [31:0] wdata, input [1:0] last);
    integer k;
    begin
      select_n <= 1'b0;
      repeat (4) @(posedge clk);
      byte_io(ins, 1'b0);
      for (k = 0; k <= last; k = k + 1)
        byte_io(wdata[31 - 8 * k -: 8], ins[7]);
      repeat (8) @(posedge clk);
      select_n <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule

// ---- tb/ccfg_top_tb.sv ----
/* Self-checking bench for ccfg_top with the host model and a result queue.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ns
module ccfg_top_tb;
  localparam [31:0] MASK = 32'hFEFFFFFF;
  reg         clk, sys_rst, ready_n, strobe;
  reg  [23:0] cdata, dor_m;
  reg  [31:0] cfg_m, v;
  wire [31:0] cfg_w;
  wire [23:0] rout;
  wire [7:0]  rx;
  wire        sclk, sel_n, sdi, sdo, soe, dso, doe, rvalid, rx_done;
  integer     err_total, tests_run, res_cnt, cyc, t, k;
  reg  [31:0] exp_q[$];
  ccfg_top u_ccfg_top (.clk(clk), .sys_rst(sys_rst), .serial_clk(sclk), .select_n(sel_n),
    .sdio_in(sdi), .sdio_out(sdo), .sdio_oe(soe), .dedicated_serial_out(dso),
    .dedicated_serial_oe(doe), .result_ready_n(ready_n), .conv_strobe(strobe),
    .conv_data(cdata), .bias_enable(cfg_w[31]), .internal_ref_enable(cfg_w[30]),
    .result_format_select(cfg_w[29]), .unipolar_enable(cfg_w[28]),
    .byte_sequence_select(cfg_w[27]), .bit_sequence_select(cfg_w[26]),
    .output_line_select(cfg_w[25]), .modulator_resync(cfg_w[24]),
    .operating_mode_field(cfg_w[23:21]), .gain_field(cfg_w[20:18]),
    .input_channel_field(cfg_w[17:16]), .modulator_speed_field(cfg_w[15:13]),
    .decimation_field(cfg_w[12:0]), .result_out(rout), .result_valid(rvalid));
  ccfg_host u_ccfg_host (.clk(clk), .serial_clk(sclk), .select_n(sel_n), .sdio_in(sdi),
    .sdio_out(sdo), .sdio_oe(soe), .ded_out(dso), .ded_oe(doe), .rx_done(rx_done),
    .rx_byte(rx));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  function [7:0] exp_byte(input [3:0] a);
    reg [7:0] b;
    integer j;
    begin
      b = (a[3:2] == 2'b01) ? cfg_m[31 - 8 * a[1:0] -: 8] :
          (a < 4'h3) ? dor_m[23 - 8 * a[1:0] -: 8] : 8'h00;
      if (a == 4'h4)
        b[0] = ready_n;
      for (j = 0; j < 8; j = j + 1)
        exp_byte[j] = cfg_m[26] ? b[7 - j] : b[j];
    end
  endfunction
  task rd(input [3:0] a, input [1:0] n);
    integer i;
    begin
      for (i = 0; i <= n; i = i + 1)
        exp_q.push_back({24'h000000, exp_byte(cfg_m[27] ? 4'(a - i) : 4'(a + i))});
      u_ccfg_host.xfer({1'b1, n, 1'b0, a}, 32'h00000000, n);
    end
  endtask
  task wr(input [3:0] a, input [1:0] n, input [31:0] d);
    integer i, r0;
    begin
      r0 = res_cnt;
      u_ccfg_host.xfer({1'b0, n, 1'b0, a}, d, n);
      for (i = 0; i <= n; i = i + 1)
        if (a + i >= 4 && a + i <= 7)
          cfg_m[63 - 8 * (a + i) -: 8] = d[31 - 8 * i -: 8];
      check(res_cnt - r0, 32'(a == 4'h4 && d[24]));
      check(cfg_w & MASK, cfg_m & MASK);
    end
  endtask
  task conv(input [23:0] d);
    begin
      cdata  <= d;
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
      dor_m = (cfg_m[28] && d[23]) ? 24'h000000 : d;
      dor_m[23] = dor_m[23] ^ cfg_m[29];
      repeat (2) @(posedge clk);
      check(rout, dor_m);
    end
  endtask
  always @(posedge clk)
  begin
    res_cnt <= sys_rst ? 0 : res_cnt + cfg_w[24];
    cyc <= cyc + 1;
    if (rx_done)
      check({24'h000000, rx}, exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
    if (cyc == 40000)
    begin
      err_total = err_total + 1;
      summarize;
    end
  end
  initial
  begin
    sys_rst = 1'b1; ready_n = 1'b1; strobe = 1'b0; cdata = 24'h000000;
    err_total = 0; tests_run = 0; res_cnt = 0; cyc = 0;
    cfg_m = 32'h40000017; dor_m = 24'h000000;
    v = $urandom(43883);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    check(cfg_w & MASK, cfg_m & MASK);
    rd(4'h4, 2'h3);
    $display("defaults done");
    for (t = 0; t < 4; t = t + 1)
    begin
      v = $urandom;
      v[27:25] = {t[0], t[1], t[0] ^ t[1]};
      ready_n <= t[0];
      wr(4'h4, 2'h3, v);
      rd(t[0] ? 4'h7 : 4'h4, 2'h3);
    end
    $display("random configuration done");
    for (t = 0; t < 4; t = t + 1)
    begin
      wr(4'h4, 2'h0, {2'b01, t[1], t[0], 28'h0000000});
      conv({1'b1, 23'($urandom)});
      conv({1'b0, 23'($urandom)});
      rd(4'h0, 2'h2);
    end
    $display("result format done");
    ready_n <= 1'b1;
    wr(4'h5, 2'h0, {cfg_m[23:18], ~cfg_m[17:16], 24'h000000});
    check(32'(rvalid), 32'h00000000);
    for (k = 1; k <= 4; k = k + 1)
    begin
      ready_n <= 1'b0;
      repeat (8) @(posedge clk);
      ready_n <= 1'b1;
      repeat (8) @(posedge clk);
      check(32'(rvalid), 32'(k == 4));
    end
    $display("channel change done");
    // Frame cut after its first data byte: only that byte lands
    cfg_m[23:16] = ~cfg_m[23:16];
    u_ccfg_host.xfer({1'b0, 2'h3, 1'b0, 4'h5}, {cfg_m[23:16], 24'h000000}, 2'h0);
    check(cfg_w & MASK, cfg_m & MASK);
    $display("cut frame done");
    wr(4'h3, 2'h0, 32'hFF000000);
    wr(4'h8, 2'h1, 32'hFFFF0000);
    wr(4'h0, 2'h0, 32'hFF000000);
    rd(4'h8, 2'h0);
    rd(4'h0, 2'h2);
    $display("unmapped access done");
    summarize;
  end
endmodule
